// *** rtl/ars_dev.sv ***
// converter end: control decode, conversion timeline, result buffer, status, serial out
// assumes host logic on the same clock, so bus pins are read without synchronisers
`timescale 1ns/10ps
module ars_dev #(
   parameter int unsigned CAL_CYCLES = ars_pkg::CAL_CYC_DEF
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // host link
   ars_if.dev_mp LINK,
   // analog side
   input wire logic [15:0] ANALOG_IN,
   output logic [6:0] MUX_CHANNEL,
   output logic HOLD
);
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL} ars_dstate_e;

   ars_dstate_e state_q;
   logic wr_n_q;
   logic rd_n_q;
   logic res_sel_q;
   logic [6:0] cnt_q;
   logic [20:0] cal_cnt_q;
   logic [7:0] acq_cnt_q;
   logic [15:0] sample_q;
   logic [15:0] shreg_q;
   logic [15:0] result_q;
   logic [6:0] pend_chan_q;
   logic fmt_word_q;
   logic hi_next_q;
   logic eoc_q;
   logic trk_done_n_q;
   logic sclk_q;
   logic sdat_q;
   logic [15:0] dout_q;
   logic wr_fall;
   logic rd_fall;
   logic sel_a;
   logic sel_b;
   logic wr_ok;
   logic start_hit;
   logic ctrl_hit;
   logic calw_hit;
   logic chan_hit;
   logic res_sel;
   logic stat_sel;
   logic cal_go;
   logic conv_done;
   logic cal_done;
   logic [7:0] status;

   // strobe edges; the strobe is caught by the master clock, hence the slip
   assign wr_fall = wr_n_q & ~LINK.wr_n;
   assign rd_fall = rd_n_q & ~LINK.rd_n;
   assign sel_a = ~LINK.chip_sel_a_n & LINK.chip_sel_b_n;
   assign sel_b = LINK.chip_sel_a_n & ~LINK.chip_sel_b_n;
   assign wr_ok = wr_fall & LINK.rd_n;
   assign start_hit = wr_ok & sel_a & ~LINK.addr_bit_hi & LINK.addr_bit_lo;
   assign calw_hit = wr_ok & sel_a & ~LINK.addr_bit_hi & ~LINK.addr_bit_lo;
   assign ctrl_hit = wr_ok & sel_a & LINK.addr_bit_hi;
   assign chan_hit = wr_fall & sel_b;
   assign res_sel = ~LINK.rd_n & sel_a & LINK.addr_bit_lo & ~LINK.addr_bit_hi;
   assign stat_sel = ~LINK.rd_n & LINK.wr_n & sel_a & ~LINK.addr_bit_lo & ~LINK.addr_bit_hi;
   assign cal_go = calw_hit | (ctrl_hit & LINK.bus_data[ars_pkg::CB_CAL]);
   assign conv_done = (state_q == ST_CONV) && (cnt_q == ars_pkg::CONV_END);
   assign cal_done = (state_q == ST_CAL) && (cal_cnt_q == 21'(CAL_CYCLES - 1));

   // edge history of the strobes
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         res_sel_q <= 1'b0;
      end else begin
         wr_n_q <= LINK.wr_n;
         rd_n_q <= LINK.rd_n;
         res_sel_q <= res_sel;
      end
   end

   // converter sequence; starts are ignored while converting or calibrating
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         state_q <= ST_IDLE;
         cnt_q <= 7'h00;
         cal_cnt_q <= 21'h000000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 7'h00;
               cal_cnt_q <= 21'h000000;
               if (cal_go) begin
                  state_q <= ST_CAL;
               end else if (start_hit) begin
                  state_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               cnt_q <= cnt_q + 7'h01;
               if (conv_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_CAL: begin
               cal_cnt_q <= cal_cnt_q + 21'h000001;
               if (cal_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // sample held at start; next channel applied at once to overlap acquisition
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         sample_q <= 16'h0000;
         pend_chan_q <= 7'h00;
         MUX_CHANNEL <= 7'h00;
      end else begin
         if (chan_hit) begin
            pend_chan_q <= LINK.bus_data[6:0];
         end
         if (state_q == ST_IDLE && start_hit && !cal_go) begin
            sample_q <= ANALOG_IN;
            MUX_CHANNEL <= pend_chan_q;
         end
      end
   end

   assign HOLD = (state_q == ST_CONV);

   // output buffer changes only at the end, so reads never see a partial code
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         result_q <= 16'h0000;
      end else if (conv_done) begin
         result_q <= sample_q;
      end
   end

   // control bits; format steers how the buffer is presented
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         fmt_word_q <= 1'b1;
      end else if (ctrl_hit) begin
         fmt_word_q <= LINK.bus_data[ars_pkg::CB_FMT];
      end
   end

   // byte pointer: high byte first, advances at the end of each byte read
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         hi_next_q <= 1'b1;
      end else if (conv_done) begin
         hi_next_q <= 1'b1;
      end else if (res_sel_q && LINK.rd_n && !fmt_word_q) begin
         hi_next_q <= ~hi_next_q;
      end
   end

   // busy flag; raised the cycle after a read or start, well inside four clocks
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         eoc_q <= 1'b0;
      end else if (rd_fall && (res_sel || stat_sel)) begin
         eoc_q <= 1'b1;
      end else if (state_q == ST_IDLE && (start_hit || cal_go)) begin
         eoc_q <= 1'b1;
      end else if (conv_done || cal_done) begin
         eoc_q <= 1'b0;
      end
   end

   // acquisition timer after each conversion or calibration
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         acq_cnt_q <= 8'h00;
         trk_done_n_q <= 1'b1;
      end else if (state_q != ST_IDLE) begin
         acq_cnt_q <= 8'h00;
         trk_done_n_q <= 1'b1;
      end else if (acq_cnt_q == ars_pkg::ACQ_CYC) begin
         trk_done_n_q <= 1'b0;
      end else begin
         acq_cnt_q <= acq_cnt_q + 8'h01;
      end
   end

   // serial out: clock falls at each decision and rises two clocks later
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         sclk_q <= 1'b1;
         sdat_q <= 1'b0;
         shreg_q <= 16'h0000;
      end else if (state_q == ST_IDLE && start_hit && !cal_go) begin
         shreg_q <= ANALOG_IN;
      end else if (state_q == ST_CONV) begin
         if (cnt_q >= ars_pkg::SER_FALL_FIRST && cnt_q <= ars_pkg::SER_FALL_LAST && cnt_q[1:0] == 2'h2) begin
            sclk_q <= 1'b0;
            sdat_q <= shreg_q[15];
            shreg_q <= {shreg_q[14:0], 1'b0};
         end
         if (cnt_q >= ars_pkg::SER_RISE_FIRST && cnt_q <= ars_pkg::SER_RISE_LAST && cnt_q[1:0] == 2'h0) begin
            sclk_q <= 1'b1;
         end
      end
   end

   // status byte; reserved bits read as zero
   always_comb begin
      status = 8'h00;
      status[ars_pkg::ST_EOC] = eoc_q;
      status[ars_pkg::ST_BYTE] = hi_next_q;
      status[ars_pkg::ST_TRKDONE] = trk_done_n_q;
      status[ars_pkg::ST_TRACK] = (state_q == ST_IDLE);
      status[ars_pkg::ST_CONV] = (state_q == ST_CONV);
      status[ars_pkg::ST_CAL] = (state_q == ST_CAL);
   end

   // read data from a flop; same path and timing for status and result
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         dout_q <= 16'h0000;
      end else if (res_sel) begin
         if (fmt_word_q) begin
            dout_q <= result_q;
         end else begin
            dout_q <= {8'h00, hi_next_q ? result_q[15:8] : result_q[7:0]};
         end
      end else begin
         dout_q <= {8'h00, status};
      end
   end

   assign LINK.dev_data = dout_q;
   assign LINK.dev_data_oe = res_sel | stat_sel;
   assign LINK.eoc = eoc_q;
   assign LINK.track_done_n = trk_done_n_q;
   assign LINK.serial_clk_out = sclk_q;
   assign LINK.serial_result_out = sdat_q;
endmodule : ars_dev

// *** rtl/ars_host.sv ***
// host end: lite bus command registers driving strobed accesses to the converter
// assumes the converter runs on the same clock; one access at a time
`timescale 1ns/10ps
module ars_host (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // converter link
   ars_if.host_mp LINK,
   // lite bus write
   input wire logic [3:0] AXI_AWADDR,
   input wire logic AXI_AWVALID,
   output logic AXI_AWREADY,
   input wire logic [31:0] AXI_WDATA,
   input wire logic [3:0] AXI_WSTRB,
   input wire logic AXI_WVALID,
   output logic AXI_WREADY,
   output logic [1:0] AXI_BRESP,
   output logic AXI_BVALID,
   input wire logic AXI_BREADY,
   // lite bus read
   input wire logic [3:0] AXI_ARADDR,
   input wire logic AXI_ARVALID,
   output logic AXI_ARREADY,
   output logic [31:0] AXI_RDATA,
   output logic [1:0] AXI_RRESP,
   output logic AXI_RVALID,
   input wire logic AXI_RREADY
);
   typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_FLOAT} ars_hstate_e;

   ars_hstate_e state_q;
   ars_pkg::ars_op_e op_q;
   logic [15:0] wdat_q;
   logic [15:0] rdat_q;
   logic [3:0] cnt_q;
   logic wait_q;
   logic conv_q;
   logic is_rd;
   logic cmd_go;
   logic wr_take;

   assign is_rd = (op_q == ars_pkg::OP_RES) || (op_q == ars_pkg::OP_STAT);
   assign wr_take = AXI_AWVALID & AXI_WVALID & ~AXI_BVALID;
   // commands written while an access runs are dropped
   assign cmd_go = wr_take && AXI_AWADDR == ars_pkg::REG_CMD && AXI_WSTRB[2] && state_q == HS_IDLE;
   assign AXI_AWREADY = wr_take;
   assign AXI_WREADY = wr_take;
   assign AXI_ARREADY = ~AXI_RVALID;

   // write response one cycle after address and data are taken together
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         AXI_BVALID <= 1'b0;
         AXI_BRESP <= ars_pkg::RESP_OKAY;
      end else if (wr_take) begin
         AXI_BVALID <= 1'b1;
         AXI_BRESP <= (AXI_AWADDR == ars_pkg::REG_CMD) ? ars_pkg::RESP_OKAY : ars_pkg::RESP_DECERR;
      end else if (AXI_BREADY) begin
         AXI_BVALID <= 1'b0;
      end
   end

   // read response one cycle after the address
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         AXI_RVALID <= 1'b0;
         AXI_RDATA <= 32'h00000000;
         AXI_RRESP <= ars_pkg::RESP_OKAY;
      end else if (AXI_ARVALID && !AXI_RVALID) begin
         AXI_RVALID <= 1'b1;
         AXI_RRESP <= ars_pkg::RESP_OKAY;
         case (AXI_ARADDR)
            ars_pkg::REG_CMD: AXI_RDATA <= {13'h0000, op_q, wdat_q};
            ars_pkg::REG_STAT: AXI_RDATA <= {29'h00000000, LINK.track_done_n, LINK.eoc, state_q != HS_IDLE};
            ars_pkg::REG_RDATA: AXI_RDATA <= {16'h0000, rdat_q};
            default: begin
               AXI_RDATA <= 32'h00000000;
               AXI_RRESP <= ars_pkg::RESP_DECERR;
            end
         endcase
      end else if (AXI_RREADY) begin
         AXI_RVALID <= 1'b0;
      end
   end

   // access sequencer: setup, strobe, then float time with address held
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         state_q <= HS_IDLE;
         op_q <= ars_pkg::OP_CTRL;
         wdat_q <= 16'h0000;
         rdat_q <= 16'h0000;
         cnt_q <= 4'h0;
         wait_q <= 1'b0;
         conv_q <= 1'b0;
      end else begin
         case (state_q)
            HS_IDLE: begin
               cnt_q <= 4'h0;
               conv_q <= conv_q & LINK.eoc; // busy left by a read is no conversion
               if (cmd_go) begin
                  op_q <= ars_pkg::ars_op_e'(AXI_WDATA[ars_pkg::CMD_OP_LSB +: 3]);
                  wdat_q <= AXI_WDATA[15:0];
                  state_q <= HS_SETUP;
               end
            end
            HS_SETUP: begin
               wait_q <= (op_q == ars_pkg::OP_RES) && LINK.eoc && conv_q;
               conv_q <= conv_q | (op_q == ars_pkg::OP_START);
               state_q <= HS_STROBE;
            end
            HS_STROBE: begin
               // a result read begun mid-conversion is stretched until done
               if (wait_q && LINK.eoc) begin
                  cnt_q <= 4'h0;
               end else if (cnt_q == (is_rd ? ars_pkg::ACC_CYC : ars_pkg::WW_CYC) - 4'h1) begin
                  if (is_rd) begin
                     rdat_q <= LINK.bus_data;
                  end
                  cnt_q <= 4'h0;
                  state_q <= HS_FLOAT;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            HS_FLOAT: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == ars_pkg::FLOAT_CYC - 4'h1) begin
                  state_q <= HS_IDLE;
               end
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end

   // pin decode per operation; pins idle deselected
   always_ff @(posedge REF_CLK) begin
      if (!RST_B || state_q == HS_IDLE) begin
         LINK.chip_sel_a_n <= 1'b1;
         LINK.chip_sel_b_n <= 1'b1;
         LINK.addr_bit_lo <= 1'b0;
         LINK.addr_bit_hi <= 1'b0;
         LINK.host_data_oe <= 1'b0;
      end else if (state_q == HS_SETUP) begin
         LINK.chip_sel_a_n <= (op_q == ars_pkg::OP_CHAN);
         LINK.chip_sel_b_n <= (op_q != ars_pkg::OP_CHAN);
         LINK.addr_bit_lo <= (op_q == ars_pkg::OP_START) || (op_q == ars_pkg::OP_RES);
         LINK.addr_bit_hi <= (op_q == ars_pkg::OP_CTRL);
         LINK.host_data_oe <= ~is_rd;
      end
   end

   // strobes low only during the strobe phase
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         LINK.rd_n <= 1'b1;
         LINK.wr_n <= 1'b1;
      end else begin
         LINK.rd_n <= ~(is_rd && (state_q == HS_SETUP || (state_q == HS_STROBE
            && ((wait_q && LINK.eoc) || cnt_q != ars_pkg::ACC_CYC - 4'h1))));
         LINK.wr_n <= ~(state_q == HS_SETUP && !is_rd) && ~(state_q == HS_STROBE && !is_rd
            && cnt_q != ars_pkg::WW_CYC - 4'h1);
      end
   end

   assign LINK.host_data = wdat_q;
endmodule : ars_host

// *** shared/ars_if.sv ***
// parallel bus, status lines and serial output between converter and host
// assumes the bench reads bus_data as the resolved level of the data lines
`timescale 1ns/10ps
interface ars_if;
   logic chip_sel_a_n;
   logic chip_sel_b_n;
   logic addr_bit_lo;
   logic addr_bit_hi;
   logic rd_n;
   logic wr_n;
   logic [15:0] host_data;
   logic host_data_oe;
   logic [15:0] dev_data;
   logic dev_data_oe;
   logic [15:0] bus_data;
   logic eoc;
   logic track_done_n;
   logic serial_clk_out;
   logic serial_result_out;
   // wire level from the enables; undriven lines read as zero
   assign bus_data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'h0000);
   modport dev_mp (input chip_sel_a_n, chip_sel_b_n, addr_bit_lo, addr_bit_hi, rd_n, wr_n, bus_data,
      output dev_data, dev_data_oe, eoc, track_done_n, serial_clk_out, serial_result_out);
   modport host_mp (output chip_sel_a_n, chip_sel_b_n, addr_bit_lo, addr_bit_hi, rd_n, wr_n,
      host_data, host_data_oe, input bus_data, eoc, track_done_n, serial_clk_out, serial_result_out);
endinterface : ars_if

// *** shared/ars_pkg.sv ***
// constants shared by the converter readout end and the host bus end
// assumes one 40 MHz clock that also serves as the converter master clock
// Behaviour
// - busy flag high converting, low done, rearmed quickly
// - mux takes next channel once conversion starts
// - result read: rd low, sel a, lo bit
// - result as one word or two bytes
// - result buffered, readable during next conversion
// - bus drive never disturbs running conversion
// - status read: rd low, sel a, bits low
// - status read timed like result read
// - status bit 0 mirrors busy flag
// - status bit 2 tells next byte
// - status bit 3 low once input acquired
// - bits 5,6,7 show track, convert, calibrate
// - status bits 1 and 4 reserved
// - result also shifted out serially, MSB first
// - serial clock falls per decision, rises later
// - receiver samples data on serial clock rise
// - first serial bit eight clocks after start
// - outputs may slip four clocks when asynchronous
// - relative timing of serial and flags fixed
// - host may stretch result read until done
// - format bit high word, low two bytes
// - start on write strobe fall, sample held
package ars_pkg;
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CHAN_W = 7;
   // acquisition: six master clocks plus 2.25 us
   localparam int unsigned T_ACQ_NS = 2250;
   localparam int unsigned ACQ_BASE_CYC = 6;
   localparam logic [7:0] ACQ_CYC = 8'(ACQ_BASE_CYC + (T_ACQ_NS * CLK_MHZ + 999) / 1000);
   // conversion timeline, counted from the cycle the start strobe is seen
   localparam logic [6:0] SER_FALL_FIRST = 7'h06;
   localparam logic [6:0] SER_FALL_LAST = 7'h42;
   localparam logic [6:0] SER_RISE_FIRST = 7'h08;
   localparam logic [6:0] SER_RISE_LAST = 7'h44;
   localparam logic [6:0] CONV_END = 7'h45;
   localparam int unsigned CAL_CYC_DEF = 1443840;
   localparam logic [1:0] EOC_RAISE_MAX = 2'h3;
   // control and status bit positions
   localparam int unsigned CB_FMT = 1;
   localparam int unsigned CB_CAL = 2;
   localparam int unsigned ST_EOC = 0;
   localparam int unsigned ST_BYTE = 2;
   localparam int unsigned ST_TRKDONE = 3;
   localparam int unsigned ST_TRACK = 5;
   localparam int unsigned ST_CONV = 6;
   localparam int unsigned ST_CAL = 7;
   // host bus timing, least times rounded up
   localparam int unsigned T_WW_NS = 40;
   localparam int unsigned T_ACC_NS = 150;
   localparam int unsigned T_FLOAT_NS = 140;
   localparam logic [3:0] WW_CYC = 4'((T_WW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] FLOAT_CYC = 4'((T_FLOAT_NS * CLK_MHZ + 999) / 1000);
   // host register map over the lite bus
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_RDATA = 4'h8;
   localparam int unsigned CMD_OP_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [2:0] {OP_CTRL, OP_START, OP_CAL, OP_CHAN, OP_RES, OP_STAT} ars_op_e;
endpackage : ars_pkg

// *** tb/ars_assertions.sv ***
// concurrent checks on the converter-to-host link signals
// assumes one clock shared by both ends; instantiated beside the interface in tb
`timescale 1ns/10ps
module ars_assertions (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // host strobes and selects
   input wire logic chip_sel_a_n,
   input wire logic chip_sel_b_n,
   input wire logic addr_bit_lo,
   input wire logic addr_bit_hi,
   input wire logic rd_n,
   input wire logic wr_n,
   // converter outputs
   input wire logic dev_data_oe,
   input wire logic eoc,
   input wire logic track_done_n,
   input wire logic serial_clk_out,
   input wire logic serial_result_out
);
   logic sel_res;
   logic sel_stat;
   logic stretch_q;
   logic conv_q;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   // select decodes; result read and conversion start share one address
   assign sel_res = !chip_sel_a_n && chip_sel_b_n && addr_bit_lo && !addr_bit_hi;
   assign sel_stat = !chip_sel_a_n && chip_sel_b_n && !addr_bit_lo && !addr_bit_hi && wr_n;
   // result read begun mid-conversion
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         stretch_q <= 1'b0;
      end else if (rd_n) begin
         stretch_q <= 1'b0;
      end else if ($fell(rd_n) && sel_res && eoc && conv_q) begin
         stretch_q <= 1'b1;
      end
   end
   // a start strobe opens a conversion, the busy flag's fall closes it
   always_ff @(posedge REF_CLK) begin
      conv_q <= RST_B && (($fell(wr_n) && sel_res && rd_n) || (conv_q && !$fell(eoc)));
   end
   AST_OE_ONLY_READ: assert property (dev_data_oe |-> !rd_n && (sel_res || sel_stat))
      else $error("data lines driven outside a selected read");
   AST_READ_DRIVES: assert property (!rd_n && (sel_res || sel_stat) |-> dev_data_oe)
      else $error("selected read without data drive");
   AST_EOC_START: assert property ($fell(wr_n) && sel_res && rd_n |-> ##[1:4] eoc)
      else $error("busy flag late after start");
   AST_EOC_READ: assert property ($fell(rd_n) && sel_res && !eoc |-> ##[1:4] eoc)
      else $error("busy flag late after result read");
   AST_SCLK_FIRST: assert property ($fell(wr_n) && sel_res && rd_n && !track_done_n
      |-> serial_clk_out [*5] ##[1:7] !serial_clk_out)
      else $error("first serial clock fall out of window");
   AST_SCLK_LOW: assert property ($fell(serial_clk_out) |=> !serial_clk_out ##1 serial_clk_out)
      else $error("serial clock low width not two cycles");
   AST_SERIAL_RESULT_OUT_STABLE: assert property (!$stable(serial_result_out) |-> !serial_clk_out || $rose(eoc))
      else $error("serial data moved while clock high");
   AST_SCLK_IN_CONV: assert property ($fell(serial_clk_out) |-> eoc)
      else $error("serial clock active while not busy");
   AST_RD_WIDTH: assert property ($fell(rd_n) |-> !rd_n [*6])
      else $error("read strobe shorter than six cycles");
   AST_WR_WIDTH: assert property ($fell(wr_n) |-> !wr_n [*2] ##1 wr_n)
      else $error("write strobe not two cycles low");
   AST_STRETCH: assert property (stretch_q && eoc |-> !rd_n)
      else $error("stretched result read released while busy");
endmodule : ars_assertions

// *** tb/tb.sv ***
// self-checking bench: host end and converter end joined by the link interface
// assumes software access over the lite bus only; analog input is a plain word
`timescale 1ns/10ps
module tb;
   logic ref_clk, rst_b, hold;
   logic [15:0] analog_in, ser_q;
   logic [6:0] mux_channel;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int ser_cnt, err_count, comparisons;
   ars_if link_if();
   // calibration shortened so a full cycle fits the run
   ars_dev #(.CAL_CYCLES(200)) ars_dev_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(link_if),
      .ANALOG_IN(analog_in), .MUX_CHANNEL(mux_channel), .HOLD(hold));
   ars_host ars_host_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(link_if), .AXI_AWADDR(awaddr),
      .AXI_AWVALID(awvalid), .AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(wstrb),
      .AXI_WVALID(wvalid), .AXI_WREADY(wready), .AXI_BRESP(bresp), .AXI_BVALID(bvalid),
      .AXI_BREADY(bready), .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid), .AXI_ARREADY(arready),
      .AXI_RDATA(rdata), .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready));
   ars_assertions ars_assertions_inst (.REF_CLK(ref_clk), .RST_B(rst_b),
      .chip_sel_a_n(link_if.chip_sel_a_n), .chip_sel_b_n(link_if.chip_sel_b_n),
      .addr_bit_lo(link_if.addr_bit_lo), .addr_bit_hi(link_if.addr_bit_hi), .rd_n(link_if.rd_n),
      .wr_n(link_if.wr_n), .dev_data_oe(link_if.dev_data_oe), .eoc(link_if.eoc),
      .track_done_n(link_if.track_done_n),
      .serial_clk_out(link_if.serial_clk_out), .serial_result_out(link_if.serial_result_out));
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // receiver side: bits taken on the serial clock rise
   always @(posedge link_if.serial_clk_out) begin
      ser_q <= {ser_q[14:0], link_if.serial_result_out};
      ser_cnt <= ser_cnt + 1;
   end
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_resp
   // waits to the edge where the signal is high
   task automatic wait_for(ref logic s);
      logic hit;
      do begin
         @(negedge ref_clk);
         hit = s;
         @(posedge ref_clk);
      end while (hit !== 1'b1);
   endtask : wait_for
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      wait_for(awready);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_for(bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_for(arready);
      arvalid <= 1'b0;
      wait_for(rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read
   // one link access, then its data
   task automatic do_op(input logic [2:0] op, input logic [15:0] d, output logic [31:0] res);
      logic [1:0] r;
      logic [31:0] s;
      axi_write(ars_pkg::REG_CMD, {13'h0000, op, d}, r);
      chk_resp(r, ars_pkg::RESP_OKAY);
      s = 32'h00000001;
      while (s[0] !== 1'b0) axi_read(ars_pkg::REG_STAT, s, r);
      axi_read(ars_pkg::REG_RDATA, res, r);
   endtask : do_op
   task automatic st_chk(input logic [7:0] mask, input logic [7:0] exp);
      logic [31:0] res;
      do_op(ars_pkg::OP_STAT, 16'h0000, res);
      chk_val({24'h000000, res[7:0] & mask}, {24'h000000, exp});
   endtask : st_chk
   task automatic sc_idle;
      logic [31:0] d;
      logic [1:0] r;
      repeat (150) @(posedge ref_clk);
      chk_val({31'h00000000, link_if.track_done_n}, 32'h00000000);
      chk_val({31'h00000000, link_if.dev_data_oe}, 32'h00000000);
      st_chk(8'hFA, 8'h20);
      axi_read(4'hC, d, r);
      chk_resp(r, ars_pkg::RESP_DECERR);
      axi_write(4'hC, 32'h00001234, r);
      chk_resp(r, ars_pkg::RESP_DECERR);
   endtask : sc_idle
   task automatic sc_cal;
      logic [31:0] d;
      do_op(ars_pkg::OP_CAL, 16'h0000, d);
      chk_val({31'h00000000, link_if.eoc}, 32'h00000001);
      st_chk(8'h81, 8'h81);
      repeat (250) @(posedge ref_clk);
      chk_val({31'h00000000, link_if.eoc}, 32'h00000000);
      st_chk(8'hC0, 8'h00);
   endtask : sc_cal
   task automatic sc_word;
      logic [31:0] d;
      do_op(ars_pkg::OP_CTRL, 16'h0002, d);
      do_op(ars_pkg::OP_CHAN, 16'h0025, d);
      analog_in <= 16'hA5C3;
      ser_cnt = 0;
      do_op(ars_pkg::OP_START, 16'h0000, d);
      chk_val({25'h0000000, mux_channel}, 32'h00000025);
      chk_val({31'h00000000, hold}, 32'h00000001);
      st_chk(8'hE1, 8'h41);
      // channel applies at next start
      do_op(ars_pkg::OP_CHAN, 16'h0012, d);
      chk_val({25'h0000000, mux_channel}, 32'h00000025);
      do_op(ars_pkg::OP_RES, 16'h0000, d);
      chk_val({16'h0000, d[15:0]}, 32'h0000A5C3);
      chk_val({16'h0000, ser_q}, 32'h0000A5C3);
      chk_val(ser_cnt, 32'h00000010);
      chk_val({31'h00000000, hold}, 32'h00000000);
      analog_in <= 16'h5A3C;
      do_op(ars_pkg::OP_START, 16'h0000, d);
      chk_val({25'h0000000, mux_channel}, 32'h00000012);
      do_op(ars_pkg::OP_RES, 16'h0000, d);
      chk_val({16'h0000, d[15:0]}, 32'h00005A3C);
   endtask : sc_word
   task automatic sc_byte;
      logic [31:0] d;
      do_op(ars_pkg::OP_CTRL, 16'h0000, d);
      analog_in <= 16'h3C96;
      do_op(ars_pkg::OP_START, 16'h0000, d);
      // read after the conversion ends
      repeat (100) @(posedge ref_clk);
      do_op(ars_pkg::OP_RES, 16'h0000, d);
      chk_val({24'h000000, d[7:0]}, 32'h0000003C);
      st_chk(8'h04, 8'h00);
      do_op(ars_pkg::OP_RES, 16'h0000, d);
      chk_val({24'h000000, d[7:0]}, 32'h00000096);
      analog_in <= 16'h69A5;
      do_op(ars_pkg::OP_START, 16'h0000, d);
      do_op(ars_pkg::OP_RES, 16'h0000, d);
      chk_val({24'h000000, d[7:0]}, 32'h00000069);
      st_chk(8'h04, 8'h00);
   endtask : sc_byte
   task automatic end_of_test;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      rst_b = 1'b0;
      analog_in = 16'h0000;
      ser_q = 16'h0000;
      awaddr = 4'h0;
      araddr = 4'h0;
      wstrb = 4'hF;
      wdata = 32'h00000000;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      err_count = 0;
      comparisons = 0;
      ser_cnt = 0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      sc_idle;
      sc_cal;
      sc_word;
      sc_byte;
      end_of_test;
   end
   // watchdog; the whole sequence needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      end_of_test;
   end
endmodule : tb
